// ===== pwm_msg_peer.sv
/*
  Peer port controller for burst-width coded low-power byte messages:
  an encoder that sends queued bytes framed by delimiters, and a decoder
  that measures received burst widths and rebuilds bytes.
  Assumes lfps_tx drives a burst generator (high = burst, low = idle),
  lfps_rx comes from a burst detector asynchronous to ref_clk, and ref_clk
  runs at the rate given by the package clock period.
*/
`timescale 1ns/1ns
`default_nettype none
// Function
// R1: A zero bit is a burst for the first third of the unit, then idle.
// R2: A one bit is a burst for the first two thirds of the unit, then idle.
// R3: The sent unit interval lies between 2 and 2.4 us, nominally 2.2 us.
// R4: Zero bursts are sent 0.5-0.80 us and accepted at 0.45-0.85 us.
// R5: One bursts are sent 1.33-1.80 us and accepted at 1.28-1.85 us.
// R6: A delimiter is one unit of burst followed by one unit of idle.
// R7: Every transmission opens with a delimiter before the first bit.
// R8: Every transmission closes with a delimiter after the last bit.
// R9: Each message is one byte, sent and rebuilt least significant first.
// R10: Back-to-back messages are separated by exactly one delimiter.
// R11: The receiver sorts each burst by width into zero, one or delimiter.
// R12: A bad width or a short byte before a delimiter drops it and errs.
module pwm_msg_peer #(
  parameter int unsigned FIFO_DEPTH = pwm_msg_pkg::FIFO_DEPTH
) (
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  input  wire logic                 tx_valid,
  output var  logic                 tx_ready,
  input  wire logic [7:0]           tx_data,
  output var  logic                 tx_busy,
  output var  logic                 lfps_tx,
  input  wire logic                 lfps_rx,
  output var  pwm_msg_pkg::rx_msg_s rx_msg
);

  typedef enum logic [1:0] {
    TX_IDLE,
    TX_DHI,
    TX_DLO,
    TX_BITS
  } tx_st_e;

  localparam logic [7:0] UI_LAST   = 8'(pwm_msg_pkg::UI_CYC - 1);
  localparam logic [7:0] ZERO_W    = 8'(pwm_msg_pkg::ZERO_TX_CYC);
  localparam logic [7:0] ONE_W     = 8'(pwm_msg_pkg::ONE_TX_CYC);
  localparam logic [3:0] BITS_LAST = 4'(pwm_msg_pkg::MSG_BITS - 1);
  localparam logic [3:0] BITS_FULL = 4'(pwm_msg_pkg::MSG_BITS);

  // Transmit state
  tx_st_e     st_r;
  tx_st_e     st_nxt;
  logic [7:0] cyc_r;
  logic [7:0] cyc_nxt;
  logic [7:0] sh_r;
  logic [7:0] sh_nxt;
  logic [3:0] bit_r;
  logic [3:0] bit_nxt;
  logic       lfps_r;
  logic       lfps_nxt;

  // Queue between user and encoder
  logic       f_valid;
  logic       f_pop;
  logic [7:0] f_data;
  logic       ui_end;

  // Receive state
  logic                 rx_s;
  logic                 rx_prev_r;
  logic [7:0]           bw_r;
  logic [7:0]           bw_nxt;
  logic [7:0]           asm_r;
  logic [7:0]           asm_nxt;
  logic [3:0]           rcnt_r;
  logic [3:0]           rcnt_nxt;
  pwm_msg_pkg::rx_msg_s msg_r;
  pwm_msg_pkg::rx_msg_s msg_nxt;
  logic                 rx_fall;
  logic                 is_zero;
  logic                 is_one;
  logic                 is_delim;

  byte_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_txq (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .ce        (ce),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (tx_data),
    .out_valid (f_valid),
    .out_ready (f_pop),
    .out_data  (f_data)
  );

  pin_sync3 u_rxsync (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .ce        (ce),
    .pin_in    (lfps_rx),
    .level_out (rx_s)
  );

  assign ui_end = (cyc_r == UI_LAST); // R3

  // Encoder: delimiter, eight bits, delimiter, shared between messages
  always_comb begin
    st_nxt  = st_r;
    cyc_nxt = cyc_r;
    sh_nxt  = sh_r;
    bit_nxt = bit_r;
    f_pop   = 1'b0;
    unique case (st_r)
      TX_IDLE: begin
        if (f_valid) begin
          st_nxt  = TX_DHI; // R7
          cyc_nxt = 8'h00;
        end
      end
      TX_DHI: begin
        cyc_nxt = cyc_r + 8'h01;
        if (ui_end) begin
          st_nxt  = TX_DLO; // R6
          cyc_nxt = 8'h00;
        end
      end
      TX_DLO: begin
        cyc_nxt = cyc_r + 8'h01;
        if (ui_end) begin
          cyc_nxt = 8'h00;
          if (f_valid) begin
            f_pop   = 1'b1; // R10
            sh_nxt  = f_data;
            bit_nxt = 4'h0;
            st_nxt  = TX_BITS;
          end else begin
            st_nxt = TX_IDLE;
          end
        end
      end
      TX_BITS: begin
        cyc_nxt = cyc_r + 8'h01;
        if (ui_end) begin
          cyc_nxt = 8'h00;
          sh_nxt  = {1'b0, sh_r[7:1]}; // R9
          bit_nxt = bit_r + 4'h1;
          if (bit_r == BITS_LAST) begin
            st_nxt = TX_DHI; // R8
          end
        end
      end
    endcase
    // Burst level aligned to the next state and cycle
    lfps_nxt = (st_nxt == TX_DHI) ||
               ((st_nxt == TX_BITS) &&
                (cyc_nxt < (sh_nxt[0] ? ONE_W : ZERO_W))); // R1 R2
  end

  // Encoder registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r   <= TX_IDLE;
      cyc_r  <= 8'h00;
      sh_r   <= 8'h00;
      bit_r  <= 4'h0;
      lfps_r <= 1'b0;
    end else if (ce) begin
      st_r   <= st_nxt;
      cyc_r  <= cyc_nxt;
      sh_r   <= sh_nxt;
      bit_r  <= bit_nxt;
      lfps_r <= lfps_nxt;
    end
  end

  assign lfps_tx = lfps_r;
  assign tx_busy = (st_r != TX_IDLE);

  // Burst width classification on the falling edge
  assign rx_fall  = rx_prev_r && !rx_s;
  assign is_zero  = pwm_msg_pkg::in_win(bw_r, pwm_msg_pkg::ZERO_RX_MIN,
                                        pwm_msg_pkg::ZERO_RX_MAX); // R4
  assign is_one   = pwm_msg_pkg::in_win(bw_r, pwm_msg_pkg::ONE_RX_MIN,
                                        pwm_msg_pkg::ONE_RX_MAX); // R5
  assign is_delim = (bw_r >= 8'(pwm_msg_pkg::DELIM_RX_MIN)); // R11

  // Decoder: count burst, then shift a bit in or close the byte
  always_comb begin
    bw_nxt        = rx_s ? pwm_msg_pkg::sat_inc8(bw_r) : 8'h00;
    asm_nxt       = asm_r;
    rcnt_nxt      = rcnt_r;
    msg_nxt       = msg_r;
    msg_nxt.valid = 1'b0;
    msg_nxt.err   = 1'b0;
    if (rx_fall) begin
      if (is_zero || is_one) begin
        if (rcnt_r == BITS_FULL) begin
          msg_nxt.err = 1'b1; // R12
          rcnt_nxt    = 4'h0;
        end else begin
          asm_nxt  = {is_one, asm_r[7:1]}; // R9 R11
          rcnt_nxt = rcnt_r + 4'h1;
        end
      end else if (is_delim) begin
        if (rcnt_r == BITS_FULL) begin
          msg_nxt.valid = 1'b1; // R10
          msg_nxt.data  = asm_r;
        end else if (rcnt_r != 4'h0) begin
          msg_nxt.err = 1'b1; // R12
        end
        rcnt_nxt = 4'h0;
      end else begin
        msg_nxt.err = 1'b1; // R12
        rcnt_nxt    = 4'h0;
      end
    end
  end

  // Decoder registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_prev_r <= 1'b0;
      bw_r      <= 8'h00;
      asm_r     <= 8'h00;
      rcnt_r    <= 4'h0;
      msg_r     <= '0;
    end else if (ce) begin
      rx_prev_r <= rx_s;
      bw_r      <= bw_nxt;
      asm_r     <= asm_nxt;
      rcnt_r    <= rcnt_nxt;
      msg_r     <= msg_nxt;
    end
  end

  assign rx_msg = msg_r;

  // Checking helpers: burst run length and spacing of burst starts
  localparam int HI_ZERO = pwm_msg_pkg::ZERO_TX_CYC;
  localparam int HI_ONE  = pwm_msg_pkg::ONE_TX_CYC;
  localparam int HI_UI   = pwm_msg_pkg::UI_CYC;
  logic [7:0] run_r;
  logic [7:0] gap_r;
  logic       prev_tx_r;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      run_r     <= 8'h00;
      gap_r     <= 8'hff;
      prev_tx_r <= 1'b0;
    end else if (ce) begin
      run_r     <= lfps_r ? pwm_msg_pkg::sat_inc8(run_r) : 8'h00;
      gap_r     <= (lfps_r && !prev_tx_r) ? 8'h01 :
                   (st_r == TX_IDLE)      ? 8'hff : // Idle forgets spacing
                                            pwm_msg_pkg::sat_inc8(gap_r);
      prev_tx_r <= lfps_r;
    end
  end

  default clocking cb @(posedge ref_clk iff ce);
  endclocking
  default disable iff (rst);

  sequence bit_zero_end;
    (st_r == TX_BITS) && !sh_r[0] && $fell(lfps_r);
  endsequence

  sequence bit_one_end;
    (st_r == TX_BITS) && sh_r[0] && $fell(lfps_r);
  endsequence

  sequence delim_tail;
    (st_r == TX_DLO) && $fell(lfps_r);
  endsequence

  zero_burst_a: assert property (bit_zero_end |-> run_r == 8'(HI_ZERO)) // R1
    else $error("zero burst has wrong width");
  one_burst_a: assert property (bit_one_end |-> run_r == 8'(HI_ONE)) // R2
    else $error("one burst has wrong width");
  delim_burst_a: assert property (delim_tail |-> run_r == 8'(HI_UI)) // R6
    else $error("delimiter burst is not one unit");
  unit_spacing_a: assert property ($rose(lfps_r) |-> // R3
      (gap_r == 8'(HI_UI)) || (gap_r == 8'(2 * HI_UI)) || (gap_r == 8'hff))
    else $error("burst starts not spaced by whole units");
  open_delim_a: assert property ((st_r == TX_IDLE) ##1 (st_r != TX_IDLE) // R7
      |-> (st_r == TX_DHI) && lfps_r)
    else $error("message did not open with a delimiter");
  close_delim_a: assert property ((st_r == TX_BITS) ##1 (st_r != TX_BITS) // R8
      |-> (st_r == TX_DHI) && ($past(bit_r) == BITS_LAST))
    else $error("eight bits not followed by a delimiter");
  lsb_first_a: assert property (f_pop |=> (sh_r == $past(f_data)) // R9
      ##(HI_UI) (sh_r == ($past(f_data, HI_UI + 1) >> 1)))
    else $error("byte not shifted out low bit first");
  one_delim_a: assert property ((st_r == TX_DLO) && ui_end // R10
      && f_valid |=> (st_r == TX_BITS) && (cyc_r == 8'h00))
    else $error("queued message not sent after one delimiter");
  short_byte_a: assert property (rx_fall && is_delim // R12
      && (rcnt_r != 4'h0) && (rcnt_r != BITS_FULL)
      |=> msg_r.err && !msg_r.valid)
    else $error("short byte before delimiter not flagged");
  long_byte_a: assert property (rx_fall && (is_zero || is_one) // R12
      && (rcnt_r == BITS_FULL) |=> msg_r.err && (rcnt_r == 4'h0))
    else $error("ninth bit not flagged");
  bad_width_a: assert property (rx_fall && !is_zero && !is_one && !is_delim // R11
      |=> msg_r.err ##1 (rcnt_r == 4'h0))
    else $error("illegal burst width not rejected");

endmodule
`default_nettype wire

// ===== pwm_msg_pkg.sv
/*
  Shared constants, record types and helper functions for the low-power
  burst-width message peer: timing in nanoseconds, cycle counts derived
  from them, and the received-message record.
  Assumes a single local timing clock whose period is CLK_NS.
*/
`default_nettype none
package pwm_msg_pkg;

  // Local timing clock
  localparam int unsigned CLK_NS = 40;

  // Transmit timing, nanoseconds
  localparam int unsigned UI_NS       = 2200; // Nominal bit unit interval
  localparam int unsigned UI_MIN_NS   = 2000;
  localparam int unsigned UI_MAX_NS   = 2400;
  localparam int unsigned ZERO_TX_NS  = 733;  // One third of a unit
  localparam int unsigned ONE_TX_NS   = 1467; // Two thirds of a unit

  // Receive acceptance windows, nanoseconds
  localparam int unsigned ZERO_RX_MIN_NS  = 450;
  localparam int unsigned ZERO_RX_MAX_NS  = 850;
  localparam int unsigned ONE_RX_MIN_NS   = 1280;
  localparam int unsigned ONE_RX_MAX_NS   = 1850;
  localparam int unsigned DELIM_RX_MIN_NS = 1900;

  // Cycle counts: nominal and longest round down, least round up
  localparam int unsigned UI_CYC       = UI_NS / CLK_NS;
  localparam int unsigned ZERO_TX_CYC  = ZERO_TX_NS / CLK_NS;
  localparam int unsigned ONE_TX_CYC   = ONE_TX_NS / CLK_NS;
  localparam int unsigned ZERO_RX_MIN  = (ZERO_RX_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned ZERO_RX_MAX  = ZERO_RX_MAX_NS / CLK_NS;
  localparam int unsigned ONE_RX_MIN   = (ONE_RX_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned ONE_RX_MAX   = ONE_RX_MAX_NS / CLK_NS;
  localparam int unsigned DELIM_RX_MIN = (DELIM_RX_MIN_NS + CLK_NS - 1) / CLK_NS;

  // Message geometry
  localparam int unsigned MSG_BITS   = 8;
  localparam int unsigned FIFO_DEPTH = 8;

  // Received message, one-cycle valid or error pulse with its byte
  typedef struct packed {
    logic       valid;
    logic       err;
    logic [7:0] data;
  } rx_msg_s;

  // Saturating increment of an 8-bit counter
  function automatic logic [7:0] sat_inc8(input logic [7:0] v);
    return (v == 8'hff) ? v : v + 8'h01;
  endfunction

  // Width inside an inclusive window of cycles
  function automatic logic in_win(input logic [7:0] w,
                                  input int unsigned lo,
                                  input int unsigned hi);
    return (w >= 8'(lo)) && (w <= 8'(hi));
  endfunction

endpackage
`default_nettype wire

// ===== pin_sync3.sv
/*
  Three-stage synchroniser for a single pin level; the output moves only
  once the second and third stages agree.
  Assumes the pin is asynchronous to ref_clk and that ce gates all state.
*/
`timescale 1ns/1ns
`default_nettype none
module pin_sync3 (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic pin_in,
  output var  logic level_out
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic out_r;
  logic out_nxt;

  // Accept a new level only when the late stages agree
  always_comb begin
    out_nxt = (s2_r == s3_r) ? s2_r : out_r;
  end

  // Stage registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s1_r  <= 1'b0;
      s2_r  <= 1'b0;
      s3_r  <= 1'b0;
      out_r <= 1'b0;
    end else if (ce) begin
      s1_r  <= pin_in;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      out_r <= out_nxt;
    end
  end

  assign level_out = out_r;

endmodule
`default_nettype wire

// ===== byte_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides, width and depth set by
  parameters.
  Assumes one clock; ce low freezes pointers and contents.
*/
`timescale 1ns/1ns
`default_nettype none
module byte_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output var  logic             out_valid,
  input  wire logic             out_ready,
  output var  logic [WIDTH-1:0] out_data
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_r;
  logic [AW-1:0]    wr_nxt;
  logic [AW-1:0]    rd_r;
  logic [AW-1:0]    rd_nxt;
  logic [AW:0]      cnt_r;
  logic [AW:0]      cnt_nxt;
  logic             push;
  logic             pop;

  // Honest full and empty from the fill count
  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rd_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointer and count updates
  always_comb begin
    wr_nxt  = wr_r;
    rd_nxt  = rd_r;
    cnt_nxt = cnt_r;
    if (push) begin
      wr_nxt = (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + AW'(1);
    end
    if (pop) begin
      rd_nxt = (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + AW'(1);
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + (AW+1)'(1);
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - (AW+1)'(1);
    end
  end

  // Pointer registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else if (ce) begin
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Storage, no reset needed
  always_ff @(posedge ref_clk) begin
    if (ce && push) begin
      mem_r[wr_r] <= in_data;
    end
  end

endmodule
`default_nettype wire

// ===== pwm_peer_model.sv
/*
  Far-end peer port model: sends burst-width coded byte messages on the
  line into the block and rebuilds the messages the block sends out.
  Assumes lfps_tx high means burst; widths are timed in nanoseconds.
*/
`timescale 1ns/1ns
`default_nettype none
module pwm_peer_model (
  input  wire logic       lfps_tx,
  output var  logic       lfps_rx,
  output var  logic       got_stb,
  output var  logic [7:0] got_data,
  output var  logic [7:0] fmt_err
);
  time        t_rise;
  time        t_fall;
  time        hi_ns;
  time        lo_ns;
  int         nbits;
  logic       in_frame;
  logic       idle_seen;
  logic [7:0] sh;

  // One burst then idle, in ns
  task automatic burst(input int unsigned h, input int unsigned l);
    lfps_rx = 1'b1;
    #(h);
    lfps_rx = 1'b0;
    #(l);
  endtask

  // Delimiter: a unit of burst, a unit of idle
  task automatic delim(input int unsigned ui);
    burst(ui, ui);
  endtask

  // Message of n bits, least significant first, closed by a delimiter
  task automatic send_msg(input logic [7:0] d, input int unsigned n,
                          input int unsigned ui, input int unsigned z,
                          input int unsigned o, input logic first);
    if (first) delim(ui);
    for (int i = 0; i < n; i++) begin
      if (d[i]) burst(o, ui - o);
      else burst(z, ui - z);
    end
    delim(ui);
  endtask

  // Sort each burst from the block and rebuild its bytes
  initial begin
    lfps_rx   = 1'b0;
    got_stb   = 1'b0;
    got_data  = 8'h00;
    fmt_err   = 8'h00;
    in_frame  = 1'b0;
    idle_seen = 1'b1;
    nbits     = 0;
    sh        = 8'h00;
    forever begin
      if (idle_seen) @(posedge lfps_tx);
      t_rise = $time;
      @(negedge lfps_tx);
      hi_ns = $time - t_rise;
      t_fall = $time;
      idle_seen = 1'b1;
      fork
        #2600;
        begin
          @(posedge lfps_tx);
          idle_seen = 1'b0;
        end
      join_any
      disable fork;
      lo_ns = $time - t_fall;
      if (hi_ns >= 2000 && hi_ns <= 2400 && lo_ns >= 2000 &&
          (idle_seen || lo_ns <= 2400)) begin
        if (in_frame && nbits == 8) begin
          got_data = sh;
          got_stb = 1'b1;
          #1 got_stb = 1'b0;
        end else if (in_frame) fmt_err = fmt_err + 8'h01;
        in_frame = !idle_seen;
        nbits = 0;
      end else if (in_frame && !idle_seen && nbits < 8 &&
                   hi_ns + lo_ns >= 2000 && hi_ns + lo_ns <= 2400 &&
                   ((hi_ns >= 500 && hi_ns <= 800) ||
                    (hi_ns >= 1330 && hi_ns <= 1800))) begin
        sh = {hi_ns >= 1330, sh[7:1]};
        nbits++;
      end else fmt_err = fmt_err + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ===== lfps_pwm_message_codec_test.sv
/*
  Self-checking bench for the burst-width message peer: user bytes out
  through the FIFO onto the link, peer messages in, good and bad.
  Assumes pwm_msg_peer, pwm_peer_model and the package are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHECK(name, exp, got) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("mismatch %s expected %h seen %h", name, exp, got); \
    end \
  end
module lfps_pwm_message_codec_test;
  logic                 ref_clk;
  logic                 rst;
  logic                 ce;
  logic                 tx_valid;
  logic                 tx_ready;
  logic [7:0]           tx_data;
  logic                 tx_busy;
  logic                 lfps_tx;
  logic                 lfps_rx;
  pwm_msg_pkg::rx_msg_s rx_msg;
  logic                 got_stb;
  logic [7:0]           got_data;
  logic [7:0]           fmt_err;
  logic [31:0]          lfsr_r;
  logic [7:0]           exp_b;
  logic [8:0]           rx_note;
  logic [7:0]           tx_q[$];
  logic [8:0]           rx_q[$];
  int                   n_mismatch;
  int                   cmp_count;

  pwm_msg_peer uut (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .ce       (ce),
    .tx_valid (tx_valid),
    .tx_ready (tx_ready),
    .tx_data  (tx_data),
    .tx_busy  (tx_busy),
    .lfps_tx  (lfps_tx),
    .lfps_rx  (lfps_rx),
    .rx_msg   (rx_msg)
  );

  pwm_peer_model peer (
    .lfps_tx  (lfps_tx),
    .lfps_rx  (lfps_rx),
    .got_stb  (got_stb),
    .got_data (got_data),
    .fmt_err  (fmt_err)
  );

  // Next pseudo-random byte
  function automatic logic [7:0] next_rand();
    lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
    return lfsr_r[7:0];
  endfunction

  // Counts, verdict, stop
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Hang guard
  initial begin
    #1000000;
    n_mismatch++;
    end_sim();
  end

  // Bytes decoded on the link against the oldest noted byte
  always @(posedge got_stb) begin
    exp_b = (tx_q.size() > 0) ? tx_q.pop_front() : 8'hxx;
    `CHECK("link byte", exp_b, got_data)
  end

  // Received message pulses against the oldest note, sampled settled
  always @(negedge ref_clk) begin
    if (rx_msg.valid === 1'b1 || rx_msg.err === 1'b1) begin
      rx_note = (rx_q.size() > 0) ? rx_q.pop_front() : 9'hxxx;
      `CHECK("rx err", rx_note[8], rx_msg.err)
      if (rx_note[8] === 1'b0) `CHECK("rx data", rx_note[7:0], rx_msg.data)
    end
  end

  // Fill the FIFO until refused, then let it drain onto the link
  task automatic tx_test();
    int n_taken;
    int k;
    n_taken = 0;
    @(negedge ref_clk);
    ce = 1'b0;
    tx_valid = 1'b1;
    tx_data = next_rand();
    repeat (20) @(negedge ref_clk);
    `CHECK("busy while frozen", 1'b0, tx_busy)
    ce = 1'b1;
    for (int i = 0; i < 12; i++) begin
      if (tx_ready === 1'b1) begin
        tx_data = next_rand();
        tx_q.push_back(tx_data);
        n_taken++;
      end else tx_data = next_rand();
      @(negedge ref_clk);
    end
    tx_valid = 1'b0;
    `CHECK("bytes taken", 8, n_taken)
    `CHECK("busy", 1'b1, tx_busy)
    for (k = 0; k < 8000 && tx_busy !== 1'b0; k++) @(negedge ref_clk);
    if (k == 8000) begin
      n_mismatch++;
      end_sim();
    end
    #3000;
    `CHECK("link bytes left", 0, tx_q.size())
    `CHECK("link format", 8'h00, fmt_err)
    $display("test tx done");
  endtask

  // Peer messages: nominal series, slow, fast, bad width, long, short byte
  task automatic rx_test();
    logic [7:0] d;
    repeat (24) @(negedge ref_clk); // Clear of the freeze in tx_test
    for (int i = 0; i < 5; i++) begin
      d = next_rand();
      rx_q.push_back({1'b0, d});
      if (i < 3) peer.send_msg(d, 8, 2200, 700, 1450, i == 0);
      else if (i == 3) peer.send_msg(d, 8, 2400, 800, 1780, 1'b1);
      else peer.send_msg(d, 8, 2000, 500, 1340, 1'b1);
      if (i >= 2) #5000;
    end
    rx_q.push_back(9'h100);
    peer.delim(2200);
    peer.burst(1000, 1200);
    peer.delim(2200);
    #5000;
    rx_q.push_back(9'h100);
    peer.delim(2200);
    repeat (9) peer.burst(700, 1500);
    peer.delim(2200);
    #5000;
    rx_q.push_back(9'h100);
    peer.send_msg(next_rand(), 5, 2200, 700, 1450, 1'b1);
    #5000;
    `CHECK("rx notes left", 0, rx_q.size())
    $display("test rx done");
  endtask

  // Reset, then both directions at once
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    lfsr_r = 32'h021f;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHECK("ready at reset", 1'b1, tx_ready)
    `CHECK("busy at reset", 1'b0, tx_busy)
    `CHECK("line at reset", 1'b0, lfps_tx)
    `CHECK("rx at reset", 10'h000, rx_msg)
    rst = 1'b0;
    $display("test reset done");
    fork
      tx_test();
      rx_test();
    join
    end_sim();
  end
endmodule
`default_nettype wire
